// *** src/dtb_consts.svh ***
// Constants for the double transmit buffer state control.
// Included by the package and the design; definitions only.
`ifndef DTB_CONSTS_SVH
`define DTB_CONSTS_SVH
`define DTB_IDX_W 7
`define DTB_IDX_COMMIT_RST 7'h00
`define DTB_IDX_TRANSMIT_RST 7'h01
`define DTB_SLOT_STAT_W 16
`define DTB_MINISLOT_W 11
`define DTB_XFER_CYCLES 2
`endif

// *** src/dtb_pkg.sv ***
// Types for the double transmit buffer state control.
// Assumes dtb_consts.svh is on the include path.
`include "dtb_consts.svh"
package dtb_pkg;
  typedef logic [`DTB_IDX_W-1:0] dtb_idx_t;
  typedef logic [`DTB_SLOT_STAT_W-1:0] dtb_stat_t;
  typedef logic [`DTB_MINISLOT_W-1:0] dtb_mslot_t;
  // Transmit side states
  typedef enum logic [3:0] {
    TS_DIS, TS_IDLE, TS_SA, TS_SA_ITX, TS_MA, TS_MA_ITX, TS_ITX, TS_TX, TS_SU
  } dtb_tx_state_e;
  // Commit side states
  typedef enum logic [2:0] {
    CS_DIS, CS_DIS_LCK, CS_IDLE, CS_LCK, CS_ITX
  } dtb_cm_state_e;
endpackage : dtb_pkg

// *** src/dtb_ctrl.sv ***
// Double transmit message buffer state control: commit side, transmit side, internal transfer.
// Assumes one clock, synchronous reset, event inputs are single-cycle pulses from same-clock logic.
// Notes on behaviour
// - Transfer start and end move both sides at once; other module transitions only transmit side.
// - Transfer start begins moving commit data to transmit side.
// - Transfer end closes transfer, at the latest in the cycle of the next slot or segment start.
// - Slot match in static slot takes slot-assigned transition.
// - Slot match with cycle filter match takes message-available transition.
// - Transmit at slot start only if committed; dynamic slot checks latest minislot.
// - End of slot enters status-updated, which updates status and flags, sets interrupt, then returns to idle.
// - Static, dynamic-or-segment and any-slot begin events are raised.
// - Module transitions beat host commands, except host disable beats slot match from idle; transfer start beats disable and lock.
// - Transfer start has the lowest priority among transmit side module transitions.
// - Message-available wins over slot-assigned from idle.
// - In message-available, transmit start wins over slot begin events.
// - Internal priorities apply to transmit side only.
// - State changes reported by enabled and locked state bits.
// - Transfer swaps the two index registers, no payload copy.
// - Swap clears/sets commit flags, sets commit interrupt, clears sent flag.
// - Commit mode select chooses streaming or immediate behaviour.
// - Transfer start enters transfer states; only transfer end leaves them.
// - Streaming: start needs idle commit, committed, allowed tx state, unsent guard.
// - Immediate: same conditions but unsent transmit data may be overwritten.
// - Lock during transfer is refused; it sets lock error flag unless transfer end fires in the same cycle.
`timescale 1ns/1ns
`include "dtb_consts.svh"
module dtb_ctrl #(
  parameter int XFER_CYCLES = `DTB_XFER_CYCLES
) (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // Host commands, one-cycle pulses; commit mode select is a level
  input wire logic host_enable_cmd_in,
  input wire logic host_disable_command_in,
  input wire logic host_lock_command_in,
  input wire logic host_unlock_cmd_in,
  input wire logic host_commit_set_in,
  input wire logic host_commit_clr_in,
  input wire logic host_irq_clr_in,
  input wire logic host_lock_err_clr_in,
  input wire logic commit_mode_select_in,
  // Protocol events and search results, one-cycle pulses; minislot and slot status inputs are levels
  input wire logic static_start_in,
  input wire logic dynamic_start_in,
  input wire logic symwin_start_in,
  input wire logic nit_start_in,
  input wire logic slot_match_in,
  input wire logic next_slot_static_in,
  input wire logic cycle_match_in,
  input wire logic slot_end_in,
  input wire dtb_pkg::dtb_mslot_t minislot_in,
  input wire dtb_pkg::dtb_mslot_t latest_transmit_minislot_in,
  input wire dtb_pkg::dtb_stat_t slot_status_in,
  // Status outputs
  output logic commit_enabled_state_bit_out,
  output logic commit_locked_state_bit_out,
  output logic transmit_enabled_state_bit_out,
  output logic commit_flag_commit_out,
  output logic commit_flag_transmit_out,
  output logic data_sent_flag_out,
  output logic commit_buffer_interrupt_flag_out,
  output logic transmit_buffer_interrupt_flag_out,
  output logic lock_error_flag_out,
  output dtb_pkg::dtb_idx_t commit_buffer_index_reg_out,
  output dtb_pkg::dtb_idx_t transmit_buffer_index_reg_out,
  output dtb_pkg::dtb_stat_t commit_slot_status_out,
  output dtb_pkg::dtb_stat_t transmit_slot_status_out,
  output logic static_slot_begin_out,
  output logic dynamic_or_segment_begin_out,
  output logic any_slot_begin_out,
  output logic transmitting_out
);
  import dtb_pkg::*;

  dtb_tx_state_e ts_q, ts_d;
  dtb_cm_state_e cs_q, cs_d;
  dtb_idx_t cidx_q, cidx_d, tidx_q, tidx_d;
  dtb_stat_t cstat_q, cstat_d, tstat_q, tstat_d;
  logic ccmt_q, ccmt_d, tcmt_q, tcmt_d, data_sent_flag_q, data_sent_flag_d;
  logic cif_q, cif_d, tif_q, tif_d, lerr_q, lerr_d;
  logic sts_q, sts_d, dss_q, dss_d, sss_q, sss_d, tx_q, tx_d;
  logic [3:0] xcnt_q, xcnt_d;
  logic ces_q, ces_d, cls_q, cls_d, tes_q, tes_d;
  logic any_start, dyn_start, xfer_start, xfer_end, tx_go;

  // Transmit side in a state that allows a transfer
  function automatic logic tx_side_ok(input dtb_tx_state_e s);
    tx_side_ok = (s == TS_IDLE) || (s == TS_SA) || (s == TS_MA);
  endfunction : tx_side_ok

  function automatic logic in_xfer(input dtb_tx_state_e s);
    in_xfer = (s == TS_ITX) || (s == TS_SA_ITX) || (s == TS_MA_ITX);
  endfunction : in_xfer

  always_comb begin
    dyn_start = dynamic_start_in | symwin_start_in | nit_start_in;
    any_start = static_start_in | dyn_start;
    tx_go = any_start && tcmt_q &&
            (static_start_in || minislot_in <= latest_transmit_minislot_in);
    // Streaming checks sent guard, immediate does not
    xfer_start = (cs_q == CS_IDLE) && ccmt_q && tx_side_ok(ts_q) && !any_start && !slot_match_in &&
                 (commit_mode_select_in || !tcmt_q || data_sent_flag_q);
    // Transfer ends after its fixed length or early at any slot start
    xfer_end = in_xfer(ts_q) && (xcnt_q == 4'(XFER_CYCLES - 1) || any_start);
  end

  always_comb begin
    ts_d = ts_q;
    cs_d = cs_q;
    cidx_d = cidx_q;
    tidx_d = tidx_q;
    cstat_d = cstat_q;
    tstat_d = tstat_q;
    ccmt_d = ccmt_q;
    tcmt_d = tcmt_q;
    data_sent_flag_d = data_sent_flag_q;
    cif_d = cif_q & ~host_irq_clr_in;
    tif_d = tif_q & ~host_irq_clr_in;
    lerr_d = lerr_q & ~host_lock_err_clr_in;
    xcnt_d = in_xfer(ts_q) ? xcnt_q + 4'h1 : 4'h0;
    sts_d = static_start_in;
    dss_d = dyn_start;
    sss_d = any_start;
    tx_d = 1'b0;
    if (xfer_end) begin
      // Swap and flag updates land together
      cidx_d = tidx_q;
      tidx_d = cidx_q;
      ccmt_d = 1'b0;
      cif_d = 1'b1;
      tcmt_d = 1'b1;
      data_sent_flag_d = 1'b0;
      cs_d = CS_IDLE;
      case (ts_q)
        TS_SA_ITX: ts_d = TS_SA;
        TS_MA_ITX: ts_d = TS_MA;
        default: ts_d = TS_IDLE;
      endcase
    end else if (xfer_start) begin
      // Both sides enter transfer; host disable and lock lose
      cs_d = CS_ITX;
      case (ts_q)
        TS_SA: ts_d = TS_SA_ITX;
        TS_MA: ts_d = TS_MA_ITX;
        default: ts_d = TS_ITX;
      endcase
    end else begin
      // Transmit side module transitions
      case (ts_q)
        TS_IDLE: begin
          if (slot_match_in && cycle_match_in) ts_d = TS_MA;
          else if (slot_match_in && next_slot_static_in) ts_d = TS_SA;
        end
        TS_SA: begin
          if (tx_go) ts_d = TS_TX;
          else if (any_start) ts_d = TS_IDLE;
        end
        TS_MA: begin
          if (tx_go) ts_d = TS_TX;
          else if (any_start) ts_d = TS_IDLE;
        end
        TS_TX: begin
          tx_d = 1'b1;
          if (slot_end_in) ts_d = TS_SU;
        end
        TS_SU: begin
          tstat_d = slot_status_in;
          cstat_d = slot_status_in;
          data_sent_flag_d = 1'b1;
          tif_d = 1'b1;
          ts_d = TS_IDLE;
        end
        default: ;
      endcase
      // Host commands, only when no module transition touches the pair
      if (host_enable_cmd_in && ts_q == TS_DIS) begin
        ts_d = TS_IDLE;
        cs_d = (cs_q == CS_DIS_LCK) ? CS_LCK : CS_IDLE;
      end else if (host_disable_command_in && ts_q == TS_IDLE && cs_q != CS_ITX) begin
        ts_d = TS_DIS;
        cs_d = (cs_q == CS_LCK) ? CS_DIS_LCK : CS_DIS;
      end else if (host_lock_command_in) begin
        if (cs_q == CS_ITX) lerr_d = 1'b1;
        else if (cs_q == CS_IDLE) cs_d = CS_LCK;
        else if (cs_q == CS_DIS) cs_d = CS_DIS_LCK;
      end else if (host_unlock_cmd_in) begin
        if (cs_q == CS_LCK) cs_d = CS_IDLE;
        else if (cs_q == CS_DIS_LCK) cs_d = CS_DIS;
      end else if (host_commit_set_in) begin
        ccmt_d = 1'b1;
      end else if (host_commit_clr_in) begin
        ccmt_d = 1'b0;
      end
    end
    // Event sets win over host clears
    if (xfer_end) cif_d = 1'b1;
    if (ts_q == TS_SU && !xfer_end) tif_d = 1'b1;
    // Status bits follow the next state so the outputs come from flops
    ces_d = (cs_d == CS_IDLE) || (cs_d == CS_LCK) || (cs_d == CS_ITX);
    cls_d = (cs_d == CS_LCK) || (cs_d == CS_DIS_LCK);
    tes_d = (ts_d != TS_DIS);
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ts_q <= TS_DIS;
      cs_q <= CS_DIS;
      cidx_q <= `DTB_IDX_COMMIT_RST;
      tidx_q <= `DTB_IDX_TRANSMIT_RST;
      cstat_q <= '0;
      tstat_q <= '0;
      ccmt_q <= 1'b0;
      tcmt_q <= 1'b0;
      data_sent_flag_q <= 1'b0;
      cif_q <= 1'b0;
      tif_q <= 1'b0;
      lerr_q <= 1'b0;
      sts_q <= 1'b0;
      dss_q <= 1'b0;
      sss_q <= 1'b0;
      tx_q <= 1'b0;
      xcnt_q <= 4'h0;
      ces_q <= 1'b0;
      cls_q <= 1'b0;
      tes_q <= 1'b0;
    end else if (ce_in) begin
      ts_q <= ts_d;
      cs_q <= cs_d;
      cidx_q <= cidx_d;
      tidx_q <= tidx_d;
      cstat_q <= cstat_d;
      tstat_q <= tstat_d;
      ccmt_q <= ccmt_d;
      tcmt_q <= tcmt_d;
      data_sent_flag_q <= data_sent_flag_d;
      cif_q <= cif_d;
      tif_q <= tif_d;
      lerr_q <= lerr_d;
      sts_q <= sts_d;
      dss_q <= dss_d;
      sss_q <= sss_d;
      tx_q <= tx_d;
      xcnt_q <= xcnt_d;
      ces_q <= ces_d;
      cls_q <= cls_d;
      tes_q <= tes_d;
    end
  end

  // Status bits reflect states
  assign commit_enabled_state_bit_out = ces_q;
  assign commit_locked_state_bit_out = cls_q;
  assign transmit_enabled_state_bit_out = tes_q;
  assign commit_flag_commit_out = ccmt_q;
  assign commit_flag_transmit_out = tcmt_q;
  assign data_sent_flag_out = data_sent_flag_q;
  assign commit_buffer_interrupt_flag_out = cif_q;
  assign transmit_buffer_interrupt_flag_out = tif_q;
  assign lock_error_flag_out = lerr_q;
  assign commit_buffer_index_reg_out = cidx_q;
  assign transmit_buffer_index_reg_out = tidx_q;
  assign commit_slot_status_out = cstat_q;
  assign transmit_slot_status_out = tstat_q;
  assign static_slot_begin_out = sts_q;
  assign dynamic_or_segment_begin_out = dss_q;
  assign any_slot_begin_out = sss_q;
  assign transmitting_out = tx_q;

  property p_swap;
    @(posedge clk_in) disable iff (srst_in)
      (ce_in && xfer_end) |=> (cidx_q == $past(tidx_q) && tidx_q == $past(cidx_q) && !ccmt_q && cif_q && tcmt_q && !data_sent_flag_q);
  endproperty
  a_swap: assert property (p_swap) else $error("Swap or flag update wrong");

  property p_xfer_bound;
    @(posedge clk_in) disable iff (srst_in)
      (ce_in && xfer_start) |=> ##[1:8] (cs_q == CS_IDLE);
  endproperty
  a_xfer_bound: assert property (p_xfer_bound) else $error("Transfer did not end");

  property p_both;
    @(posedge clk_in) disable iff (srst_in)
      in_xfer(ts_q) == (cs_q == CS_ITX);
  endproperty
  a_both: assert property (p_both) else $error("Sides not in transfer together");

  property p_lockerr;
    @(posedge clk_in) disable iff (srst_in)
      (ce_in && cs_q == CS_ITX && host_lock_command_in && !xfer_end) |=> (lerr_q && cs_q != CS_LCK);
  endproperty
  a_lockerr: assert property (p_lockerr) else $error("Lock during transfer not refused");

  property p_ma;
    @(posedge clk_in) disable iff (srst_in)
      (ce_in && ts_q == TS_IDLE && !xfer_start && slot_match_in && cycle_match_in && !host_disable_command_in)
        |=> ts_q == TS_MA;
  endproperty
  a_ma: assert property (p_ma) else $error("Message available not taken");

  property p_tx;
    @(posedge clk_in) disable iff (srst_in)
      (ce_in && ts_q == TS_MA && tx_go) |=> ts_q == TS_TX;
  endproperty
  a_tx: assert property (p_tx) else $error("Transmit start lost priority");

  property p_su;
    @(posedge clk_in) disable iff (srst_in)
      (ce_in && ts_q == TS_SU) |=> (tif_q && data_sent_flag_q && ts_q == TS_IDLE && tstat_q == $past(slot_status_in));
  endproperty
  a_su: assert property (p_su) else $error("Status update incomplete");

  property p_evt;
    @(posedge clk_in) disable iff (srst_in)
      (ce_in && nit_start_in) |=> (dss_q && sss_q && !sts_q || $past(static_start_in));
  endproperty
  a_evt: assert property (p_evt) else $error("Segment begin event missing");

  property p_is_wins;
    @(posedge clk_in) disable iff (srst_in)
      (ce_in && xfer_start) |=> (cs_q == CS_ITX && ts_q != TS_DIS);
  endproperty
  a_is_wins: assert property (p_is_wins) else $error("Transfer start lost to host command");
endmodule : dtb_ctrl

// *** bench/test_dtb_ctrl.sv ***
// Self-checking bench for the double transmit buffer state control.
// Assumes dtb_pkg and dtb_consts.svh are compiled first; the bench drives every port itself.
`timescale 1ns/1ns
module test_dtb_ctrl;
  import dtb_pkg::*;
  localparam logic [15:0] EN = 16'h0001, DIS = 16'h0002, LCK = 16'h0004, UNL = 16'h0008;
  localparam logic [15:0] CSET = 16'h0010, CCLR = 16'h0020, ICLR = 16'h0040, ECLR = 16'h0080;
  localparam logic [15:0] STA = 16'h0100, DYN = 16'h0200, SYM = 16'h0400, NIT = 16'h0800;
  localparam logic [15:0] SM = 16'h1000, NS = 16'h2000, CM = 16'h4000, SEND = 16'h8000;
  localparam int XFER = 4;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic ce_in = 1'b1;
  logic mode = 1'b0;
  logic [15:0] ev = 16'h0000;
  dtb_mslot_t mslot = 11'h010;
  dtb_mslot_t latest = 11'h008;
  dtb_stat_t stat_in = 16'h5a3c;
  logic ces, cls, tes, cfc, cft, dsf, cif, tif, lef, sb, db, ab, txing;
  dtb_idx_t cidx, tidx;
  dtb_stat_t cst, tst;
  int miscompares = 0;
  int checked = 0;
  logic [15:0] row_in [4] = '{STA, DYN, SYM, NIT};
  logic [2:0] row_exp [4] = '{3'h5, 3'h3, 3'h3, 3'h3};

  always #10 clk_in = ~clk_in;

  dtb_ctrl #(.XFER_CYCLES(XFER)) u_dut (
    .clk_in(clk_in), .srst_in(srst_in), .ce_in(ce_in),
    .host_enable_cmd_in(ev[0]), .host_disable_command_in(ev[1]),
    .host_lock_command_in(ev[2]), .host_unlock_cmd_in(ev[3]),
    .host_commit_set_in(ev[4]), .host_commit_clr_in(ev[5]),
    .host_irq_clr_in(ev[6]), .host_lock_err_clr_in(ev[7]),
    .commit_mode_select_in(mode),
    .static_start_in(ev[8]), .dynamic_start_in(ev[9]), .symwin_start_in(ev[10]), .nit_start_in(ev[11]),
    .slot_match_in(ev[12]), .next_slot_static_in(ev[13]), .cycle_match_in(ev[14]), .slot_end_in(ev[15]),
    .minislot_in(mslot), .latest_transmit_minislot_in(latest), .slot_status_in(stat_in),
    .commit_enabled_state_bit_out(ces), .commit_locked_state_bit_out(cls),
    .transmit_enabled_state_bit_out(tes), .commit_flag_commit_out(cfc),
    .commit_flag_transmit_out(cft), .data_sent_flag_out(dsf),
    .commit_buffer_interrupt_flag_out(cif), .transmit_buffer_interrupt_flag_out(tif),
    .lock_error_flag_out(lef), .commit_buffer_index_reg_out(cidx),
    .transmit_buffer_index_reg_out(tidx), .commit_slot_status_out(cst),
    .transmit_slot_status_out(tst), .static_slot_begin_out(sb),
    .dynamic_or_segment_begin_out(db), .any_slot_begin_out(ab), .transmitting_out(txing)
  );

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One-cycle pulse on the chosen inputs; returns where the answer has settled
  task automatic fire(input logic [15:0] m);
    @(posedge clk_in);
    ev <= m;
    @(posedge clk_in);
    ev <= 16'h0000;
    @(negedge clk_in);
  endtask : fire

  task automatic step(input int n);
    repeat (n) @(negedge clk_in);
  endtask : step

  task automatic results;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  initial begin
    repeat (3000) @(posedge clk_in);
    miscompares++;
    results();
  end

  initial begin
    repeat (4) @(posedge clk_in);
    srst_in <= 1'b0;
    @(negedge clk_in);
    chk("commit_index", 16'(cidx), 16'h0000);
    chk("transmit_index", 16'(tidx), 16'h0001);
    chk("enabled_bits", 16'({ces, tes, cls}), 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      fire(row_in[i]);
      chk("begin_events", 16'({sb, db, ab}), 16'(row_exp[i]));
      step(1);
      chk("begin_events_drop", 16'({sb, db, ab}), 16'h0000);
    end
    @(posedge clk_in);
    ce_in <= 1'b0;
    fire(STA);
    chk("frozen_begin", 16'({sb, db, ab}), 16'h0000);
    @(posedge clk_in);
    ce_in <= 1'b1;
    $display("test begin_events done");
    fire(EN);
    chk("enabled_bits", 16'({ces, tes, cls}), 16'h0006);
    fire(LCK);
    chk("commit_locked", 16'(cls), 16'h0001);
    fire(CSET);
    chk("commit_flag_commit", 16'(cfc), 16'h0001);
    fire(UNL);
    fire(LCK);
    chk("lock_error", 16'(lef), 16'h0001);
    chk("commit_locked", 16'(cls), 16'h0000);
    step(XFER + 4);
    chk("commit_index", 16'(cidx), 16'h0001);
    chk("transmit_index", 16'(tidx), 16'h0000);
    chk("swap_flags", 16'({cfc, cif, cft, dsf}), 16'h0006);
    chk("enabled_bits", 16'({ces, tes, cls}), 16'h0006);
    $display("test transfer done");
    fire(LCK);
    fire(CSET);
    fire(UNL);
    step(XFER + 4);
    chk("commit_index", 16'(cidx), 16'h0001);
    chk("commit_flag_commit", 16'(cfc), 16'h0001);
    @(posedge clk_in);
    mode <= 1'b1;
    ev <= DIS;
    @(posedge clk_in);
    ev <= 16'h0000;
    step(XFER + 4);
    chk("enabled_bits", 16'({ces, tes, cls}), 16'h0006);
    chk("commit_index", 16'(cidx), 16'h0000);
    chk("transmit_index", 16'(tidx), 16'h0001);
    chk("swap_flags", 16'({cfc, cft, dsf}), 16'h0002);
    @(posedge clk_in);
    mode <= 1'b0;
    $display("test commit_modes done");
    fire(LCK);
    chk("commit_locked", 16'(cls), 16'h0001);
    fire(CSET);
    step(XFER + 2);
    chk("commit_index", 16'(cidx), 16'h0000);
    fire(CCLR);
    chk("commit_flag_commit", 16'(cfc), 16'h0000);
    fire(UNL);
    chk("commit_locked", 16'(cls), 16'h0000);
    fire(ECLR);
    chk("lock_error", 16'(lef), 16'h0000);
    $display("test lock_unlock done");
    fire(SM | CM);
    fire(DYN);
    step(1);
    chk("late_minislot_tx", 16'(txing), 16'h0000);
    step(2);
    fire(SM | NS | CM);
    fire(STA);
    step(1);
    chk("static_tx", 16'(txing), 16'h0001);
    fire(SEND);
    step(3);
    chk("transmit_slot_status", tst, 16'h5a3c);
    chk("commit_slot_status", cst, 16'h5a3c);
    chk("status_flags", 16'({tif, dsf, txing}), 16'h0006);
    fire(SM | NS);
    fire(STA);
    step(1);
    chk("slot_assigned_tx", 16'(txing), 16'h0001);
    fire(SEND);
    step(3);
    fire(ICLR);
    chk("irq_flags", 16'({cif, tif}), 16'h0000);
    $display("test transmission done");
    fire(DIS);
    chk("enabled_bits", 16'({ces, tes, cls}), 16'h0000);
    $display("test disable done");
    results();
  end
endmodule : test_dtb_ctrl
